// [rtl/wac_core.sv]
// Purpose: waveform acquisition core of a load/displacement indicator
// Assumes: sensor inputs synchronous; Avalon-MM slave, one wait state per access
// Notes:   stored waveform held in an internal array, read through index/data registers
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`include "wac_defs.svh"
module wac_core (
  input  wire logic         I_SYS_CLK,
  input  wire logic         I_SRST,
  input  wire logic [5:0]   I_AVS_ADDRESS,
  input  wire logic         I_AVS_READ,
  input  wire logic         I_AVS_WRITE,
  input  wire logic [31:0]  I_AVS_WRITEDATA,
  output logic [31:0]       O_AVS_READDATA,
  output logic              O_AVS_WAITREQUEST,
  input  wire logic [15:0]  I_LOAD,
  input  wire logic         I_DPM_A,
  input  wire logic         I_DPM_B,
  input  wire logic         I_EXT_START,
  input  wire logic         I_EXT_STOP,
  input  wire logic         I_EXT_POSITION,
  input  wire logic         I_EXT_SECTION,
  input  wire logic         I_JUDGE_HIT,
  output logic              O_SECTION_STEP,
  output logic              O_SAMPLING,
  output logic              O_DONE,
  output logic              O_DISPLACEMENT_OK_OUTPUT
);
  import wac_pkg::*;

  // ------------------------------------------------------------
  // settings slots
  // ------------------------------------------------------------
  localparam int NS = `WAC_NSLOT;
  logic [3:0]  work_ff;
  logic [1:0]  start_sel    [NS];
  logic [2:0]  stop_sel     [NS];
  logic        axis_dpm     [NS];
  logic        sect_ext     [NS];
  wac_word_t   start_lvl    [NS];
  wac_word_t   stop_lvl     [NS];
  logic        ref_back_ff;
  logic [13:0] len_ff;
  logic [6:0]  filt_ff;
  wac_word_t   pos_ff;
  wac_word_t   cal_pulse_ff;
  wac_word_t   cal_disp_ff;
  wac_word_t   cal_off_ff;
  function automatic logic in_rng(input wac_word_t v, input wac_word_t lo, input wac_word_t hi);
    return (v >= lo) && (v <= hi);
  endfunction
  function automatic logic len_ok(input logic [31:0] v);
    return (v == 32'd2000) || (v == 32'd4000) || (v == 32'd6000) || (v == 32'd8000) || (v == 32'd10000);
  endfunction

  logic        acc_ff;
  logic        wr_go;
  wac_word_t   wd;
  assign wd    = I_AVS_WRITEDATA;
  assign wr_go = I_AVS_WRITE && acc_ff;
  assign O_AVS_WAITREQUEST = (I_AVS_READ || I_AVS_WRITE) && !acc_ff;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST || acc_ff)
      acc_ff <= 1'b0;
    else if (I_AVS_READ || I_AVS_WRITE)
      acc_ff <= 1'b1;
  end
  logic wsel_all_ff;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      work_ff     <= 4'h0;
      wsel_all_ff <= 1'b0;
    end else if (wr_go && I_AVS_ADDRESS == `WAC_A_WORKSEL) begin
      work_ff     <= wd[3:0];
      wsel_all_ff <= wd[4];
    end
  end
  // per-slot items; all-selection and copy handled per slot
  genvar gs;
  generate
    for (gs = 0; gs < NS; gs++) begin : g_slot
      logic hit;
      logic cp;
      assign hit = wsel_all_ff || (work_ff == 4'(gs));
      assign cp  = wr_go && I_AVS_ADDRESS == `WAC_A_COPY && wd[7:4] == 4'(gs);
      always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
          start_sel[gs] <= 2'h0;
          stop_sel[gs]  <= 3'h1;
          axis_dpm[gs]  <= 1'b0;
          sect_ext[gs]  <= 1'b0;
          start_lvl[gs] <= 32'sh0;
          stop_lvl[gs]  <= 32'sh0;
        end else if (cp) begin
          start_sel[gs] <= start_sel[wd[3:0]];
          stop_sel[gs]  <= stop_sel[wd[3:0]];
          axis_dpm[gs]  <= axis_dpm[wd[3:0]];
          sect_ext[gs]  <= sect_ext[wd[3:0]];
          start_lvl[gs] <= start_lvl[wd[3:0]];
          stop_lvl[gs]  <= stop_lvl[wd[3:0]];
        end else if (wr_go && hit) begin
          if (I_AVS_ADDRESS == `WAC_A_CFG && wd[1:0] <= 2'h2 && wd[6:4] <= 3'h4) begin
            start_sel[gs] <= wd[1:0];
            stop_sel[gs]  <= wd[6:4];
            axis_dpm[gs]  <= wd[8];
            sect_ext[gs]  <= wd[9];
          end
          if (I_AVS_ADDRESS == `WAC_A_START_LVL && in_rng(wd, `WAC_DPM_MIN, `WAC_DPM_MAX))
            start_lvl[gs] <= wd;
          if (I_AVS_ADDRESS == `WAC_A_STOP_LVL && in_rng(wd, `WAC_DPM_MIN, `WAC_DPM_MAX))
            stop_lvl[gs] <= wd;
        end
      end
    end
  endgenerate
  wac_start_t cur_start;
  wac_stop_t  cur_stop;
  assign cur_start = wac_start_t'(start_sel[work_ff]);
  assign cur_stop  = wac_stop_t'(stop_sel[work_ff]);
  // ------------------------------------------------------------
  // displacement count, calibration, filter
  // ------------------------------------------------------------
  logic [1:0]  ab_ff;
  wac_word_t   cnt_ff;
  wac_word_t   nxt_cnt;
  wac_word_t   dpm_raw;
  wac_word_t   dpm_ff;
  logic        pos_cmd;
  logic        boot_ff;
  always_comb begin
    nxt_cnt = cnt_ff;
    case ({ab_ff, I_DPM_A, I_DPM_B})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: nxt_cnt = cnt_ff + 32'sd1;
      4'b0001, 4'b0111, 4'b1110, 4'b1000: nxt_cnt = cnt_ff - 32'sd1;
      default: nxt_cnt = cnt_ff;
    endcase
  end
  assign pos_cmd = wr_go && I_AVS_ADDRESS == `WAC_A_CTRL && wd[2];
  assign dpm_raw = wac_word_t'((64'(cnt_ff) * 64'(cal_disp_ff)) / 64'(cal_pulse_ff)) + cal_off_ff;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      ab_ff   <= 2'h0;
      cnt_ff  <= 32'sh0;
      boot_ff <= 1'b1;
    end else begin
      ab_ff   <= {I_DPM_A, I_DPM_B};
      boot_ff <= 1'b0;
      if (boot_ff || pos_cmd || I_EXT_POSITION)
        cnt_ff <= 32'sh0; // offset then set to position below
      else
        cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      cal_pulse_ff <= 32'sd1;
      cal_disp_ff  <= 32'sd1;
      cal_off_ff   <= 32'sh0;
      pos_ff       <= 32'sh0;
      ref_back_ff  <= 1'b0;
      len_ff       <= 14'd2000;
      filt_ff      <= 7'h0;
    end else begin
      if (boot_ff || pos_cmd || I_EXT_POSITION)
        cal_off_ff <= pos_ff;
      if (wr_go) begin
        case (I_AVS_ADDRESS)
          `WAC_A_CAL_PULSE: if (in_rng(wd, 1, `WAC_PULSE_MAX)) cal_pulse_ff <= wd;
          `WAC_A_CAL_DISP:  if (in_rng(wd, -`WAC_DISP_CAL_MAX, `WAC_DISP_CAL_MAX)) cal_disp_ff <= wd;
          `WAC_A_ACT_CAL:   if (in_rng(wd, `WAC_DPM_MIN, `WAC_DPM_MAX))
            cal_off_ff <= wd - (dpm_raw - cal_off_ff);
          `WAC_A_POS:       if (in_rng(wd, `WAC_DPM_MIN, `WAC_DPM_MAX)) pos_ff <= wd;
          `WAC_A_LEN:       if (len_ok(wd)) len_ff <= wd[13:0];
          `WAC_A_FILT:      if (in_rng(wd, 0, `WAC_FILT_MAX)) filt_ff <= wd[6:0];
          `WAC_A_CTRL:      ref_back_ff <= wd[3];
          default: ;
        endcase
      end
    end
  end
  // sample tick
  logic [13:0] div_ff;
  logic        tick;
  assign tick = (div_ff == 14'(`WAC_SAMPLE_DIV - 1));
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST || tick)
      div_ff <= 14'h0;
    else
      div_ff <= div_ff + 14'h1;
  end
  // moving average over filt_ff samples
  wac_word_t   hist [`WAC_FILT_MAX];
  logic [5:0]  hp_ff;
  wac_word_t   sum_ff;
  wac_word_t   clamp;
  assign clamp = (dpm_raw < `WAC_DPM_MIN) ? `WAC_DPM_MIN : (dpm_raw > `WAC_DPM_MAX) ? `WAC_DPM_MAX : dpm_raw;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      hp_ff  <= 6'h0;
      sum_ff <= 32'sh0;
      dpm_ff <= 32'sh0;
      for (int i = 0; i < `WAC_FILT_MAX; i++)
        hist[i] <= 32'sh0;
    end else if (tick) begin
      if (filt_ff == 7'h0) begin
        dpm_ff <= clamp;
      end else begin
        hist[hp_ff] <= clamp;
        sum_ff      <= sum_ff + clamp - hist[hp_ff];
        dpm_ff      <= (sum_ff + clamp - hist[hp_ff]) / wac_word_t'(filt_ff);
        hp_ff       <= (7'(hp_ff) + 7'h1 >= filt_ff) ? 6'h0 : hp_ff + 6'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // measurement sequence
  // ------------------------------------------------------------
  wac_state_t  st_ff;
  wac_word_t   load;
  wac_word_t   lvl_st;
  wac_word_t   lvl_sp;
  logic        above_ff;
  logic        stop_now;
  logic [15:0] tcnt_ff;
  logic [15:0] stall_ff;
  wac_word_t   best_ff;
  logic [11:0] npts_ff;
  assign load   = wac_word_t'(signed'(I_LOAD));
  assign lvl_st = start_lvl[work_ff];
  assign lvl_sp = stop_lvl[work_ff];
  assign O_SECTION_STEP = I_EXT_SECTION && sect_ext[work_ff] && !ref_back_ff && O_SAMPLING;
  logic reset_cmd;
  assign reset_cmd = wr_go && I_AVS_ADDRESS == `WAC_A_CTRL && wd[0];
  wac_word_t sel_v;
  assign sel_v = (cur_start == WAC_SC_EXT_DPM) ? dpm_ff : load;
  logic        fstop_ff;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST || !O_SAMPLING) fstop_ff <= 1'b0;
    else if (wr_go && I_AVS_ADDRESS == `WAC_A_CTRL && wd[1]) fstop_ff <= 1'b1; // kept until a tick acts on it
  end
  always_comb begin
    stop_now = I_EXT_STOP || fstop_ff;
    case (cur_stop)
      WAC_SP_LOAD:  stop_now = stop_now || (load >= lvl_sp);
      WAC_SP_PTS:   stop_now = stop_now || (npts_ff > 12'(`WAC_MAX_PTS - 1));
      WAC_SP_TIME:  stop_now = stop_now || (wac_word_t'(tcnt_ff) >= lvl_sp * `WAC_SAMPLES_PER_TENTH);
      WAC_SP_DPM:   stop_now = stop_now || (dpm_ff >= lvl_sp);
      WAC_SP_STALL: stop_now = stop_now || (wac_word_t'(stall_ff) >= lvl_sp * `WAC_SAMPLES_PER_TENTH);
      default:      stop_now = stop_now;
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      st_ff    <= WAC_ST_IDLE;
      above_ff <= 1'b0;
      O_DONE   <= 1'b0;
    end else if (reset_cmd) begin
      st_ff  <= WAC_ST_IDLE;
      O_DONE <= tick && O_SAMPLING && (stop_now || npts_ff == 12'(`WAC_MAX_PTS)); // set wins over clear
    end else if (tick) begin
      above_ff <= sel_v >= lvl_st;
      case (st_ff)
        WAC_ST_IDLE:     if (I_EXT_START && !O_DONE)
          st_ff <= (cur_start == WAC_SC_EXT) ? WAC_ST_SAMPLING : WAC_ST_WAIT_LVL;
        WAC_ST_WAIT_LVL: if ((sel_v >= lvl_st) != above_ff) st_ff <= WAC_ST_SAMPLING;
        WAC_ST_SAMPLING: if (stop_now || npts_ff == 12'(`WAC_MAX_PTS)) begin
          st_ff  <= WAC_ST_IDLE;
          O_DONE <= 1'b1;
        end
        default: st_ff <= WAC_ST_IDLE;
      endcase
    end
  end
  assign O_SAMPLING = (st_ff == WAC_ST_SAMPLING);
  // ------------------------------------------------------------
  // waveform store
  // ------------------------------------------------------------
  // time mode decimates on write, keeping one sample per step in a ring; the buffer holds the last 2048 kept points
  wac_word_t   wave [`WAC_MAX_PTS];
  logic [10:0] wp_ff;
  logic [15:0] dec_ff;
  logic [15:0] step;
  wac_word_t   next_dpm_ff;
  wac_word_t   res;
  logic [3:0]  skip_ff;
  logic        pace_err_ff;
  assign res  = wac_word_t'(len_ff) / `WAC_PTS_PER_LEN;
  assign step = 16'((32'(len_ff) * `WAC_SPS) / (`WAC_PTS_PER_LEN * 1000)); // samples per point, length in ms

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST || reset_cmd) begin
      wp_ff       <= 11'h0;
      npts_ff     <= 12'h0;
      tcnt_ff     <= 16'h0;
      stall_ff    <= 16'h0;
      dec_ff      <= 16'h0;
      best_ff     <= 32'sh0;
      skip_ff     <= 4'h0;
      pace_err_ff <= !I_SRST && tick && O_SAMPLING && axis_dpm[work_ff] && (dpm_ff >= next_dpm_ff + res)
                     && (skip_ff >= 4'(`WAC_SKIP_ERR - 1)); // set wins over clear
      next_dpm_ff <= 32'sh0;
    end else if (tick && st_ff == WAC_ST_WAIT_LVL) begin
      next_dpm_ff <= dpm_ff + res;
    end else if (tick && O_SAMPLING) begin
      tcnt_ff  <= tcnt_ff + 16'h1;
      stall_ff <= (dpm_ff > best_ff) ? 16'h0 : stall_ff + 16'h1;
      if (dpm_ff > best_ff) best_ff <= dpm_ff;
      if (!axis_dpm[work_ff]) begin
        // time axis: every sample counted, one per decimation step kept
        dec_ff <= (dec_ff + 16'h1 >= step) ? 16'h0 : dec_ff + 16'h1;
        if (dec_ff == 16'h0 || I_JUDGE_HIT) begin
          wave[wp_ff] <= load;
          wp_ff       <= wp_ff + 11'h1;
          if (npts_ff != 12'(`WAC_MAX_PTS)) npts_ff <= npts_ff + 12'h1;
        end
      end else if (dpm_ff >= next_dpm_ff) begin
        wave[wp_ff] <= load;
        wp_ff       <= wp_ff + 11'h1;
        if (npts_ff != 12'(`WAC_MAX_PTS)) npts_ff <= npts_ff + 12'h1;
        next_dpm_ff <= next_dpm_ff + res;
        if (dpm_ff >= next_dpm_ff + res) begin
          if (skip_ff != 4'hf) skip_ff <= skip_ff + 4'h1;
          if (skip_ff >= 4'(`WAC_SKIP_ERR - 1)) pace_err_ff <= 1'b1;
        end
      end else if (I_JUDGE_HIT && wp_ff != 11'h0) begin
        wave[wp_ff - 11'h1] <= load;
      end
    end
  end
  assign O_DISPLACEMENT_OK_OUTPUT = !pace_err_ff;
  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  logic [10:0] ridx_ff;
  logic [10:0] phys;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST)
      ridx_ff <= 11'h0;
    else if (wr_go && I_AVS_ADDRESS == `WAC_A_WAVE_IDX)
      ridx_ff <= wd[10:0];
  end
  // front: index 0 is the start point; back: index 0 is the stop point, counting back
  assign phys = ref_back_ff ? (wp_ff - 11'h1 - ridx_ff)
                            : ((npts_ff == 12'(`WAC_MAX_PTS)) ? wp_ff + ridx_ff : ridx_ff);
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_AVS_READDATA <= 32'h0;
    end else if (I_AVS_READ && !acc_ff) begin
      case (I_AVS_ADDRESS)
        `WAC_A_CTRL:      O_AVS_READDATA <= {28'h0, ref_back_ff, 3'h0};
        `WAC_A_STATUS:    O_AVS_READDATA <= {26'h0, pace_err_ff, O_DONE, 2'h0, st_ff};
        `WAC_A_WORKSEL:   O_AVS_READDATA <= {27'h0, wsel_all_ff, work_ff};
        `WAC_A_CFG:       O_AVS_READDATA <= {22'h0, sect_ext[work_ff], axis_dpm[work_ff], 1'b0,
                                             stop_sel[work_ff], 2'h0, start_sel[work_ff]};
        `WAC_A_START_LVL: O_AVS_READDATA <= lvl_st;
        `WAC_A_STOP_LVL:  O_AVS_READDATA <= lvl_sp;
        `WAC_A_POS:       O_AVS_READDATA <= pos_ff;
        `WAC_A_CAL_PULSE: O_AVS_READDATA <= cal_pulse_ff;
        `WAC_A_CAL_DISP:  O_AVS_READDATA <= cal_disp_ff;
        `WAC_A_ACT_CAL:   O_AVS_READDATA <= cal_off_ff;
        `WAC_A_FILT:      O_AVS_READDATA <= {25'h0, filt_ff};
        `WAC_A_LEN:       O_AVS_READDATA <= {18'h0, len_ff};
        `WAC_A_POINTS:    O_AVS_READDATA <= {20'h0, npts_ff};
        `WAC_A_DPM:       O_AVS_READDATA <= dpm_ff;
        `WAC_A_WAVE_IDX:  O_AVS_READDATA <= {21'h0, ridx_ff};
        `WAC_A_WAVE_DAT:  O_AVS_READDATA <= wave[phys];
        default:          O_AVS_READDATA <= 32'h0;
      endcase
    end
  end
endmodule

// [rtl/wac_defs.svh]
// Purpose: timing counts, ranges and register map of the waveform acquisition core
// Assumes: 50 MHz system clock
// Notes:   included by the core, the testbench and the port checks
`ifndef WAC_DEFS_SVH
`define WAC_DEFS_SVH
`define WAC_CLK_HZ          50000000
`define WAC_SPS             4000
`define WAC_SAMPLE_DIV      (`WAC_CLK_HZ / `WAC_SPS)
`define WAC_PTS_PER_LEN     2000
`define WAC_MAX_PTS         2048
`define WAC_SKIP_ERR        10
`define WAC_LOAD_MIN        (-9999)
`define WAC_LOAD_MAX        9999
`define WAC_DPM_MIN         (-9999)
`define WAC_DPM_MAX         32000
`define WAC_PULSE_MAX       1000000
`define WAC_DISP_CAL_MAX    99999
`define WAC_TSTOP_MIN       1
`define WAC_TSTOP_MAX       100
`define WAC_SAMPLES_PER_TENTH 400
`define WAC_NSLOT           16
`define WAC_FILT_MAX        64
// register word addresses (byte address / 4)
`define WAC_A_CTRL          6'h00
`define WAC_A_STATUS        6'h01
`define WAC_A_WORKSEL       6'h02
`define WAC_A_COPY          6'h03
`define WAC_A_CFG           6'h04
`define WAC_A_START_LVL     6'h05
`define WAC_A_STOP_LVL      6'h06
`define WAC_A_POS           6'h07
`define WAC_A_CAL_PULSE     6'h08
`define WAC_A_CAL_DISP      6'h09
`define WAC_A_ACT_CAL       6'h0a
`define WAC_A_FILT          6'h0b
`define WAC_A_LEN           6'h0c
`define WAC_A_POINTS        6'h0d
`define WAC_A_DPM           6'h0e
`define WAC_A_WAVE_IDX      6'h0f
`define WAC_A_WAVE_DAT      6'h10
`define WAC_WORKSEL_ALL     5'h10
`endif

// [rtl/wac_pkg.sv]
// Purpose: types of the waveform acquisition core
// Assumes: wac_defs.svh holds all numbers
// Notes:   none
package wac_pkg;
  typedef enum logic [1:0] {WAC_ST_IDLE, WAC_ST_WAIT_OFF, WAC_ST_WAIT_LVL, WAC_ST_SAMPLING} wac_state_t;
  typedef enum logic [1:0] {WAC_SC_EXT, WAC_SC_EXT_LOAD, WAC_SC_EXT_DPM} wac_start_t;
  typedef enum logic [2:0] {WAC_SP_LOAD, WAC_SP_PTS, WAC_SP_TIME, WAC_SP_DPM, WAC_SP_STALL} wac_stop_t;
  typedef logic signed [31:0] wac_word_t;
endpackage

// [tb/testbench.sv]
// Purpose: register and measurement tests of the core
// Assumes: one wait state per access, tick every 12500 clocks
// Notes: external stop and judgment input held low
`timescale 1ns/100ps
`include "wac_defs.svh"
module testbench;
  import wac_pkg::*;
  logic        clk;
  logic        srst;
  logic [5:0]  adr;
  logic        rd_en;
  logic        wr_en;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        wreq;
  logic [15:0] load;
  logic        dpm_a;
  logic        dpm_b;
  logic        ext_start;
  logic        ext_pos;
  logic        ext_sect;
  logic        sect_step;
  logic        sampling;
  logic        done;
  logic        displacement_ok_output;
  int          fails;
  int          check_count;
  // ----------------
  // range table: legal value, then a refused one
  // ----------------
  localparam int NR = 7;
  logic [5:0] r_adr [NR] = '{`WAC_A_LEN, `WAC_A_LEN, `WAC_A_CAL_PULSE, `WAC_A_CAL_DISP,
                            `WAC_A_FILT, `WAC_A_POS, `WAC_A_POS};
  wac_word_t  r_good [NR] = '{2000, 10000, 1000000, -99999, 64, 32000, -9999};
  wac_word_t  r_bad [NR] = '{3000, 12000, 0, 100000, 65, 32001, -10000};
  always #10 clk = ~clk;
  wac_core uut (
    .I_SYS_CLK(clk), .I_SRST(srst), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd_en),
    .I_AVS_WRITE(wr_en), .I_AVS_WRITEDATA(wdat), .O_AVS_READDATA(rdat),
    .O_AVS_WAITREQUEST(wreq), .I_LOAD(load), .I_DPM_A(dpm_a), .I_DPM_B(dpm_b),
    .I_EXT_START(ext_start), .I_EXT_STOP(1'b0), .I_EXT_POSITION(ext_pos),
    .I_EXT_SECTION(ext_sect), .I_JUDGE_HIT(1'b0), .O_SECTION_STEP(sect_step),
    .O_SAMPLING(sampling), .O_DONE(done), .O_DISPLACEMENT_OK_OUTPUT(displacement_ok_output));
  wac_sensor_model sensor (.i_clk(clk), .o_load(load), .o_dpm_a(dpm_a), .o_dpm_b(dpm_b));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge; read data taken at that edge
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    rd_en <= !w;
    wr_en <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    r = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (n >= 100) chk("waitrequest", 32'h0, 32'h1);
  endtask
  task automatic put(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic get(input string name, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(name, exp, r);
  endtask
  task automatic wait_high(input string name, input logic sel);
    int n;
    n = 0;
    while ((sel ? done : sampling) !== 1'b1 && n < 26000) begin
      @(negedge clk);
      n++;
    end
    chk(name, 32'h1, {31'h0, sel ? done : sampling});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    adr = 6'h0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdat = 32'h0;
    ext_start = 1'b0;
    ext_pos = 1'b0;
    ext_sect = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < NR; i++) begin
      put(r_adr[i], r_good[i]);
      put(r_adr[i], r_bad[i]);
      get("range", r_adr[i], r_good[i]);
    end
    get("unmapped", 6'h3f, 32'h0);
    put(`WAC_A_FILT, 32'h0);
    $display("test ranges done");
    put(`WAC_A_WORKSEL, 32'h10);
    put(`WAC_A_START_LVL, -9999);
    put(`WAC_A_START_LVL, 32001);
    for (int s = 0; s < 16; s++) begin
      put(`WAC_A_WORKSEL, s);
      get("slot start level", `WAC_A_START_LVL, -9999);
    end
    put(`WAC_A_WORKSEL, 32'h3);
    put(`WAC_A_CFG, 32'h220);
    put(`WAC_A_STOP_LVL, 32000);
    put(`WAC_A_COPY, 32'h93);
    put(`WAC_A_WORKSEL, 32'h9);
    get("copied cfg", `WAC_A_CFG, 32'h220);
    get("copied stop level", `WAC_A_STOP_LVL, 32000);
    $display("test slots done");
    put(`WAC_A_POS, -50);
    put(`WAC_A_CTRL, 32'h4);
    repeat (12600) @(posedge clk);
    get("preset", `WAC_A_DPM, -50);
    put(`WAC_A_POS, 321);
    ext_pos <= 1'b1;
    repeat (4) @(posedge clk);
    ext_pos <= 1'b0;
    repeat (12600) @(posedge clk);
    get("external preset", `WAC_A_DPM, 321);
    put(`WAC_A_ACT_CAL, 500);
    $display("test preset done");
    put(`WAC_A_CTRL, 32'h1);
    ext_start <= 1'b1;
    wait_high("sampling", 1'b0);
    get("status sampling", `WAC_A_STATUS, 32'h3);
    get("actual cal", `WAC_A_DPM, 500);
    sensor.set_load(16'h0100);
    sensor.move(8, 1'b1);
    ext_sect <= 1'b1;
    @(negedge clk);
    chk("section front", 32'h1, {31'h0, sect_step});
    put(`WAC_A_CTRL, 32'h8);
    @(negedge clk);
    chk("section back", 32'h0, {31'h0, sect_step});
    get("reference", `WAC_A_CTRL, 32'h8);
    ext_start <= 1'b0;
    ext_sect <= 1'b0;
    put(`WAC_A_CTRL, 32'ha);
    wait_high("done", 1'b1);
    get("status done", `WAC_A_STATUS, 32'h10);
    put(`WAC_A_CTRL, 32'h1);
    @(negedge clk);
    chk("done cleared", 32'h0, {31'h0, done});
    chk("displacement ok", 32'h1, {31'h0, displacement_ok_output});
    $display("test measurement done");
    report_and_stop;
  end
  // tests need at most about 51000 cycles; cut off well past that
  initial begin
    repeat (98000) @(posedge clk);
    chk("watchdog", 32'h0, 32'h1);
    report_and_stop;
  end
endmodule

// [tb/wac_props.sv]
// Purpose: port checks on the acquisition core
// Assumes: one clock, sync reset
// Notes: bound to every core instance
`timescale 1ns/100ps
`include "wac_defs.svh"
module wac_props (
  input wire logic        I_SYS_CLK,
  input wire logic        I_SRST,
  input wire logic [5:0]  I_AVS_ADDRESS,
  input wire logic        I_AVS_READ,
  input wire logic        I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic        O_AVS_WAITREQUEST,
  input wire logic        I_EXT_SECTION,
  input wire logic        O_SECTION_STEP,
  input wire logic        O_SAMPLING,
  input wire logic        O_DONE,
  input wire logic        O_DISPLACEMENT_OK_OUTPUT
);
  // ----------------
  // helpers
  // ----------------
  // stop waits for the next tick: one tick period plus slack
  localparam int STOP_LIMIT = 12510;
  logic        req;
  logic        ctrl_acc;
  logic        ref_back_ff;
  logic        stop_pend_ff;
  logic [15:0] stop_cnt_ff;
  assign req = I_AVS_READ | I_AVS_WRITE;
  assign ctrl_acc = I_AVS_WRITE & ~O_AVS_WAITREQUEST & (I_AVS_ADDRESS == `WAC_A_CTRL);
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) ref_back_ff <= 1'b0;
    else if (ctrl_acc) ref_back_ff <= I_AVS_WRITEDATA[3];
  end
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST || !O_SAMPLING) stop_pend_ff <= 1'b0;
    else if (ctrl_acc && I_AVS_WRITEDATA[1]) stop_pend_ff <= 1'b1;
  end
  always_ff @(posedge I_SYS_CLK) begin
    if (!stop_pend_ff) stop_cnt_ff <= 16'h0;
    else stop_cnt_ff <= stop_cnt_ff + 16'h1;
  end
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);
  a_one_wait_state: assert property (req && !$past(req) |-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST)
    else $error("access without exactly one wait state");
  a_no_early_answer: assert property (req && !O_AVS_WAITREQUEST |-> $past(O_AVS_WAITREQUEST) && $past(req))
    else $error("answer without a prior wait cycle");
  a_rdata_stands: assert property ($changed(O_AVS_READDATA) |-> $past(I_AVS_READ))
    else $error("read data moved without a read");
  a_section_gate: assert property (O_SECTION_STEP |-> I_EXT_SECTION && O_SAMPLING && !ref_back_ff)
    else $error("section step passed while blocked");
  a_force_stop_bound: assert property (stop_cnt_ff <= STOP_LIMIT)
    else $error("forced stop not obeyed in time");
  a_done_after_stop: assert property ($rose(O_DONE) |-> !O_SAMPLING && ($past(O_SAMPLING) || $past(O_SAMPLING, 2)))
    else $error("done rose without end of sampling");
  a_done_clear: assert property (ctrl_acc && I_AVS_WRITEDATA[0] && !O_SAMPLING |=> !O_DONE)
    else $error("done not cleared by control write");
  a_ok_at_release: assert property ($fell(I_SRST) |-> O_DISPLACEMENT_OK_OUTPUT)
    else $error("displacement ok low after reset");
  a_ok_falls_sampling: assert property ($fell(O_DISPLACEMENT_OK_OUTPUT) |-> O_SAMPLING || $past(O_SAMPLING))
    else $error("displacement ok fell outside measurement");
endmodule
bind wac_core wac_props u_props (
  .I_SYS_CLK(I_SYS_CLK), .I_SRST(I_SRST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
  .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_EXT_SECTION(I_EXT_SECTION),
  .O_SECTION_STEP(O_SECTION_STEP), .O_SAMPLING(O_SAMPLING), .O_DONE(O_DONE),
  .O_DISPLACEMENT_OK_OUTPUT(O_DISPLACEMENT_OK_OUTPUT));

// [tb/wac_sensor_model.sv]
// Purpose: load sensor and quadrature encoder feeding the core
// Assumes: moved by bench tasks
// Notes: one encoder line changes per step, slow pace
`timescale 1ns/100ps
module wac_sensor_model (
  input  wire logic        i_clk,
  output logic [15:0]      o_load,
  output logic             o_dpm_a,
  output logic             o_dpm_b
);
  logic [1:0] phase_ff;
  initial begin
    o_load = 16'h0;
    phase_ff = 2'h0;
  end
  // gray order: a leads b when moving up
  assign o_dpm_a = phase_ff[0] ^ phase_ff[1];
  assign o_dpm_b = phase_ff[1];
  task automatic move(input int quarters, input logic up);
    for (int i = 0; i < quarters; i++) begin
      repeat (16) @(posedge i_clk);
      phase_ff <= up ? phase_ff + 2'h1 : phase_ff - 2'h1;
    end
  endtask
  task automatic set_load(input logic [15:0] v);
    @(posedge i_clk);
    o_load <= v;
  endtask
endmodule
